/* common/ts_pkg.sv */
`default_nettype none
package ts_pkg;

  // Bus address of this slave
  localparam logic [6:0] SLAVE_ADDR = 7'h4C;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Read pointers
  localparam logic [7:0] RP_LT_HI = 8'h00;
  localparam logic [7:0] RP_RT_HI = 8'h01;
  localparam logic [7:0] RP_FLAGS = 8'h02;
  localparam logic [7:0] RP_CFG = 8'h03;
  localparam logic [7:0] RP_RATE = 8'h04;
  localparam logic [7:0] RP_LTH_HI = 8'h05;
  localparam logic [7:0] RP_LTL_HI = 8'h06;
  localparam logic [7:0] RP_RTH_HI = 8'h07;
  localparam logic [7:0] RP_RTL_HI = 8'h08;
  localparam logic [7:0] RP_RT_LO = 8'h10;
  localparam logic [7:0] RP_LT_LO = 8'h15;
  localparam logic [7:0] RP_MAKER = 8'hFE;
  localparam logic [7:0] RP_PART = 8'hFF;
  // Write-only pointers
  localparam logic [7:0] WP_CFG = 8'h09;
  localparam logic [7:0] WP_RATE = 8'h0A;
  localparam logic [7:0] WP_LTH_HI = 8'h0B;
  localparam logic [7:0] WP_LTL_HI = 8'h0C;
  localparam logic [7:0] WP_RTH_HI = 8'h0D;
  localparam logic [7:0] WP_RTL_HI = 8'h0E;
  localparam logic [7:0] WP_ONESHOT = 8'h0F;
  // Shared read/write pointers
  localparam logic [7:0] P_RTH_LO = 8'h13;
  localparam logic [7:0] P_RTL_LO = 8'h14;
  localparam logic [7:0] P_LTH_LO = 8'h16;
  localparam logic [7:0] P_LTL_LO = 8'h17;
  localparam logic [7:0] P_RCRIT = 8'h19;
  localparam logic [7:0] P_RES = 8'h1A;
  localparam logic [7:0] P_LCRIT = 8'h20;
  localparam logic [7:0] P_HYST = 8'h21;
  localparam logic [7:0] P_FAULT = 8'h22;

  // Writable bits and fixed bits
  localparam logic [7:0] CFG_WMASK = 8'hE4;
  localparam logic [7:0] RATE_WMASK = 8'h0F;
  localparam logic [7:0] LO_WMASK = 8'hF0;
  localparam logic [7:0] RES_WMASK = 8'h03;
  localparam logic [7:0] RES_FIXED = 8'h1C;
  localparam logic [7:0] FAULT_WMASK = 8'h8E;
  localparam logic [7:0] FAULT_FIXED = 8'h01;
  localparam int BUS_TIMEOUT_ENABLE_BIT = 7;

  // Bus timeout
  localparam int TIMEOUT_US = 30000;
  localparam int CLK_MHZ = 250;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WR, S_RD, S_DONE} ts_state_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lth_hi;
    logic [7:0] lth_lo;
    logic [7:0] ltl_hi;
    logic [7:0] ltl_lo;
    logic [7:0] rth_hi;
    logic [7:0] rth_lo;
    logic [7:0] rtl_hi;
    logic [7:0] rtl_lo;
    logic [7:0] rcrit;
    logic [7:0] lcrit;
    logic [7:0] hyst;
    logic [7:0] res;
    logic [7:0] fault;
  } ts_regs_t;

  typedef struct packed {
    logic [11:0] local_temp;
    logic [11:0] remote_temp;
    logic [7:0] flags;
  } ts_meas_t;

  localparam ts_regs_t REGS_RESET = '{cfg: 8'h00, rate: 8'h08, lth_hi: 8'h55,
    lth_lo: 8'h00, ltl_hi: 8'h00, ltl_lo: 8'h00, rth_hi: 8'h55, rth_lo: 8'h00,
    rtl_hi: 8'h00, rtl_lo: 8'h00, rcrit: 8'h55, lcrit: 8'h55, hyst: 8'h0A,
    res: 8'h1C, fault: 8'h81};
  localparam logic [7:0] PTR_RESET = 8'h00;

endpackage
`default_nettype wire

/* hdl/ts_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module ts_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // Two stages; the first feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      dout <= RST;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // ts_sync
`default_nettype wire

/* hdl/ts_link_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
module ts_link_sampler (
  input wire logic scl_clk,
  input wire logic rst_n,
  input wire logic sda_in,
  output logic bit_q,
  output logic tgl_q
);
  // Data bit taken on the bus clock; toggle marks a new bit.
  // Bit stays put until the next rising edge, long after the toggle lands.
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 1'b1;
      tgl_q <= 1'b0;
    end else begin
      bit_q <= sda_in;
      tgl_q <= ~tgl_q;
    end
  end
endmodule // ts_link_sampler
`default_nettype wire

/* hdl/ts_smbus_slave.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: SDA falling while SCL high marks a start.
// R2: SDA rising while SCL high marks a stop.
// R3: After start, shift address plus direction; answer only to address 4Ch.
// R4: Acknowledge by holding SDA low across the whole ninth clock.
// R5: Bytes are eight clocks MSB first, then one acknowledge from the receiver.
// R6: SDA moves only while SCL low; high-phase changes are start or stop.
// R7: Pure slave, never drives SCL; runs at fast and high-speed rates.
// R8: First byte after a write address becomes the pointer.
// R9: Reads use the last written pointer, which reads never change.
// R10: Master sets the pointer with a short write, then restarts to read.
// R11: Two-byte transfers move the upper byte first, lower byte second.
// R12: With timeout enabled, a line low about 30 ms resets the interface.
// R13: On timeout release SDA and wait for a new start.
// R14: Master keeps SCL at 1 kHz or faster to avoid timeout.
// R15: Timeout enable bit comes up set after reset.
// R16: Master sets byte count freely; receiver acknowledges every byte.
// R17: Master not-acknowledging a read byte makes the slave release SDA.
// R18: Config, rate and upper-limit registers have separate read and write pointers.
// R19: Temperature registers are read-only; lower bytes carry four bits high.
// R20: Configuration read 03, written 09, bits 7, 6, 5, 2, resets 00.
// R21: Rate register read 04, written 0A, four-bit code, resets 08.
// R22: Fault register at 22: enable bit 7, code bits 3-1, bit 0 one.
// R23: Pointer is eight bits and clears at power-on.
// R24: Write to one-shot pointer starts a conversion, data dropped.
module ts_smbus_slave #(
  parameter int unsigned TIMEOUT_CYCLES = ts_pkg::TIMEOUT_CYC,
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'h3A,
  parameter logic [7:0] PART_CODE = 8'h27
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire ts_pkg::ts_meas_t meas,
  output ts_pkg::ts_regs_t regs,
  output logic oneshot
);
  import ts_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

  // Synchronised pin levels and edge history
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;

  // Bits crossing from the bus-clock domain
  logic bit_val;
  logic bit_tgl;
  logic tgl_s;
  logic tgl_p_q;

  // Events
  logic rise_ev;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic ack_clk;
  logic tmo_hit;

  // Protocol state
  ts_state_t state_q;
  ts_state_t state_d;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic ack_pend_q;
  logic ack_want;
  logic [7:0] ptr_q;
  logic [7:0] cur_q;
  logic [7:0] cur_d;
  logic load_tx;
  logic [7:0] tx_q;
  logic [3:0] lt_snap_q;
  logic [3:0] rt_snap_q;
  logic [TW-1:0] tmo_cnt_q;
  logic sda_oe_q;
  logic oneshot_q;
  ts_regs_t regs_q;

  // Only SDA is ever driven, and only low; SCL is input only
  assign sda_out = 1'b0; // R7
  assign sda_oe = sda_oe_q;
  assign regs = regs_q;
  assign oneshot = oneshot_q;

  // Upper byte maps to its lower byte for two-byte transfers
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    case (p)
      RP_LT_HI: next_ptr = RP_LT_LO;
      RP_RT_HI: next_ptr = RP_RT_LO;
      RP_LTH_HI: next_ptr = P_LTH_LO;
      RP_LTL_HI: next_ptr = P_LTL_LO;
      RP_RTH_HI: next_ptr = P_RTH_LO;
      RP_RTL_HI: next_ptr = P_RTL_LO;
      WP_LTH_HI: next_ptr = P_LTH_LO;
      WP_LTL_HI: next_ptr = P_LTL_LO;
      WP_RTH_HI: next_ptr = P_RTH_LO;
      WP_RTL_HI: next_ptr = P_RTL_LO;
      default: next_ptr = p;
    endcase
  endfunction

  // Read data by read pointer; unknown pointers read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    case (p)
      RP_LT_HI: rd_mux = meas.local_temp[11:4]; // R19
      RP_RT_HI: rd_mux = meas.remote_temp[11:4]; // R19
      RP_LT_LO: rd_mux = {lt_snap_q, 4'h0}; // R19
      RP_RT_LO: rd_mux = {rt_snap_q, 4'h0}; // R19
      RP_FLAGS: rd_mux = meas.flags;
      RP_CFG: rd_mux = regs_q.cfg; // R18
      RP_RATE: rd_mux = regs_q.rate;
      RP_LTH_HI: rd_mux = regs_q.lth_hi;
      RP_LTL_HI: rd_mux = regs_q.ltl_hi;
      RP_RTH_HI: rd_mux = regs_q.rth_hi;
      RP_RTL_HI: rd_mux = regs_q.rtl_hi;
      P_LTH_LO: rd_mux = regs_q.lth_lo;
      P_LTL_LO: rd_mux = regs_q.ltl_lo;
      P_RTH_LO: rd_mux = regs_q.rth_lo;
      P_RTL_LO: rd_mux = regs_q.rtl_lo;
      P_RCRIT: rd_mux = regs_q.rcrit;
      P_LCRIT: rd_mux = regs_q.lcrit;
      P_HYST: rd_mux = regs_q.hyst;
      P_RES: rd_mux = regs_q.res;
      P_FAULT: rd_mux = regs_q.fault;
      RP_MAKER: rd_mux = MAKER_CODE;
      RP_PART: rd_mux = PART_CODE;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Pins idle high, so the synchronisers reset high
  ts_sync #(.W(2), .RST(2'b11)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({scl_clk, sda_in}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Sampling of data happens on the bus clock itself
  ts_link_sampler u_link (
    .scl_clk(scl_clk),
    .rst_n(rst_n),
    .sda_in(sda_in),
    .bit_q(bit_val),
    .tgl_q(bit_tgl)
  );

  ts_sync #(.W(1), .RST(1'b0)) u_tgl_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(bit_tgl),
    .dout(tgl_s)
  );

  // Edge history of the synchronised levels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      tgl_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      tgl_p_q <= tgl_s;
    end
  end

  // SDA edges with SCL steady high are control events
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // R1 R6
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s; // R2 R6
  assign rise_ev = tgl_s ^ tgl_p_q;
  assign scl_fall = scl_p_q & ~scl_s;
  assign byte_done = rise_ev && (cnt_q == BIT_ACK - 4'h1);
  assign ack_clk = rise_ev && (cnt_q == BIT_ACK);
  assign tmo_hit = (tmo_cnt_q >= TMO_LAST);

  // Bit counter and receive shifter, MSB first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
    end else if (start_ev || stop_ev || tmo_hit) begin
      cnt_q <= 4'h0;
    end else if (rise_ev) begin
      if (cnt_q == BIT_ACK) begin
        cnt_q <= 4'h0; // R5
      end else begin
        cnt_q <= cnt_q + 4'h1;
        sr_q <= {sr_q[6:0], bit_val}; // R5
      end
    end
  end

  // Which bytes earn an acknowledge
  always_comb begin
    case (state_q)
      S_ADDR: ack_want = (sr_q[6:0] == SLAVE_ADDR); // R3
      S_PTR: ack_want = 1'b1; // R16
      S_WR: ack_want = 1'b1; // R16
      default: ack_want = 1'b0;
    endcase
  end

  // Decisions taken on the acknowledge clock
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    load_tx = 1'b0;
    case (state_q)
      S_ADDR: begin
        if (!ack_pend_q) begin
          state_d = S_DONE;
        end else if (sr_q[0]) begin
          state_d = S_RD;
          cur_d = ptr_q; // R9 R10
          load_tx = 1'b1;
        end else begin
          state_d = S_PTR;
        end
      end
      S_PTR: begin
        state_d = S_WR;
        cur_d = sr_q; // R8
      end
      S_WR: begin
        cur_d = next_ptr(cur_q); // R11
      end
      S_RD: begin
        if (bit_val) begin
          state_d = S_DONE; // R17
        end else begin
          cur_d = next_ptr(cur_q); // R11
          load_tx = 1'b1;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
  end

  // Transfer state; timeout wins over everything
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ack_pend_q <= 1'b0;
    end else if (tmo_hit || stop_ev) begin
      state_q <= S_IDLE; // R13
      ack_pend_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= S_ADDR; // R3
      ack_pend_q <= 1'b0;
    end else if (byte_done) begin
      ack_pend_q <= ack_want;
    end else if (ack_clk) begin
      ack_pend_q <= 1'b0;
      state_q <= state_d;
    end
  end

  // Pointer only changes on a write; reads walk a private copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= PTR_RESET; // R23
      cur_q <= PTR_RESET;
    end else if (ack_clk) begin
      if (state_q == S_PTR) begin
        ptr_q <= sr_q; // R8
      end
      cur_q <= cur_d; // R9
    end
  end

  // Transmit byte and lower-byte snapshots of the same conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      lt_snap_q <= 4'h0;
      rt_snap_q <= 4'h0;
    end else if (ack_clk && load_tx) begin
      tx_q <= rd_mux(cur_d);
      if (cur_d != RP_LT_LO) begin
        lt_snap_q <= meas.local_temp[3:0];
      end
      if (cur_d != RP_RT_LO) begin
        rt_snap_q <= meas.remote_temp[3:0];
      end
    end
  end

  // Register writes through write pointers; fixed bits forced
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs_q <= REGS_RESET; // R15 R20 R21 R22
      oneshot_q <= 1'b0;
    end else begin
      oneshot_q <= 1'b0;
      if (ack_clk && state_q == S_WR) begin
        case (cur_q)
          WP_CFG: regs_q.cfg <= sr_q & CFG_WMASK; // R18 R20
          WP_RATE: regs_q.rate <= sr_q & RATE_WMASK; // R21
          WP_LTH_HI: regs_q.lth_hi <= sr_q; // R18
          WP_LTL_HI: regs_q.ltl_hi <= sr_q;
          WP_RTH_HI: regs_q.rth_hi <= sr_q;
          WP_RTL_HI: regs_q.rtl_hi <= sr_q;
          P_LTH_LO: regs_q.lth_lo <= sr_q & LO_WMASK;
          P_LTL_LO: regs_q.ltl_lo <= sr_q & LO_WMASK;
          P_RTH_LO: regs_q.rth_lo <= sr_q & LO_WMASK;
          P_RTL_LO: regs_q.rtl_lo <= sr_q & LO_WMASK;
          P_RCRIT: regs_q.rcrit <= sr_q;
          P_LCRIT: regs_q.lcrit <= sr_q;
          P_HYST: regs_q.hyst <= sr_q;
          P_RES: regs_q.res <= (sr_q & RES_WMASK) | RES_FIXED;
          P_FAULT: regs_q.fault <= (sr_q & FAULT_WMASK) | FAULT_FIXED; // R22
          WP_ONESHOT: oneshot_q <= 1'b1; // R24
          default: ;
        endcase
      end
    end
  end

  // SDA moves after SCL falls, so it is stable while high; start, stop and timeout release it at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_q <= 1'b0;
    end else if (tmo_hit || start_ev || stop_ev) begin
      sda_oe_q <= 1'b0; // R13
    end else if (scl_fall) begin
      if (cnt_q == BIT_ACK && ack_pend_q) begin
        sda_oe_q <= 1'b1; // R4
      end else if (state_q == S_RD && cnt_q != BIT_ACK) begin
        sda_oe_q <= ~tx_q[~cnt_q[2:0]]; // R5 R11
      end else begin
        sda_oe_q <= 1'b0; // R17
      end
    end
  end

  // Either line low inside a frame counts toward the timeout
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt_q <= '0;
    end else if (state_q != S_IDLE && regs_q.fault[BUS_TIMEOUT_ENABLE_BIT] && !(scl_s && sda_s)
                 && !tmo_hit) begin
      tmo_cnt_q <= tmo_cnt_q + TW'(1); // R12
    end else begin
      tmo_cnt_q <= '0;
    end
  end
endmodule // ts_smbus_slave
`default_nettype wire

/* test/ts_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ts_assertions
  import ts_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 2000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire ts_pkg::ts_regs_t regs,
  input wire logic oneshot
);
  // Length of the present stretch with either line low
  int unsigned low_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= 0;
    end else begin
      low_cnt_q <= (!scl_clk || !sda_in) ? low_cnt_q + 1 : 0;
    end
  end

  // Everything here lives in the system clock domain
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rst_n);

  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  reset_values_a: assert property ($rose(rst_n) |-> regs == REGS_RESET && !sda_oe)
    else $error("wrong state after reset");
  fault_fixed_a: assert property (regs.fault[0] && regs.fault[6:4] == 3'b000)
    else $error("fixed fault bits lost");
  cfg_bits_a: assert property ((regs.cfg & ~CFG_WMASK) == 8'h00)
    else $error("unused config bits set");
  rate_bits_a: assert property (regs.rate[7:4] == 4'h0)
    else $error("rate upper bits set");
  lo_nibble_a: assert property (((regs.lth_lo | regs.rth_lo) & 8'h0F) == 8'h00)
    else $error("lower limit nibble set");
  oneshot_pulse_a: assert property (oneshot |=> !oneshot)
    else $error("trigger longer than a cycle");
  data_change_a: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("data moved with clock high");
  ack_hold_a: assert property ($rose(scl_clk) && sda_oe |=> sda_oe [*8])
    else $error("data low not held through clock high");
  bus_release_a: assert property (regs.fault[7] && low_cnt_q == TIMEOUT_CYCLES + 16
    |-> !sda_oe)
    else $error("bus not released after timeout");
endmodule // ts_assertions

bind ts_smbus_slave ts_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .scl_clk(scl_clk),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .regs(regs),
  .oneshot(oneshot)
);
`default_nettype wire

/* test/ts_master.sv */
`timescale 1ns/100ps
`default_nettype none
module ts_master #(
  parameter real HALF = 80.0
) (
  output var logic scl,
  output var logic sda_pull,
  input wire logic sda
);
  // Clock stands high between frames, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves mid low phase so no edge meets a clock change
  task automatic bit_cycle(input logic b, output logic s);
    #(HALF);
    sda_pull = !b;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    s = sda;
    #(HALF);
    scl = 1'b0;
  endtask
  // Works from idle and as a repeated start
  task automatic start();
    #(HALF);
    sda_pull = 1'b0;
    #(HALF);
    scl = 1'b1;
    #(2 * HALF);
    sda_pull = 1'b1;
    #(2 * HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF);
    sda_pull = 1'b1;
    #(HALF);
    scl = 1'b1;
    #(2 * HALF);
    sda_pull = 1'b0;
    #(2 * HALF);
  endtask
  // Eight bits then the acknowledge slot; reads pass FF
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], q[i]);
    end
    bit_cycle(mack, ack);
  endtask
endmodule // ts_master
`default_nettype wire

/* test/ts_smbus_slave_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ts_smbus_slave_tb;
  import ts_pkg::*;
  localparam int unsigned TO_CYC = 2000;
  localparam logic [7:0] MAKER = 8'h5D; // Arbitrary identification value
  typedef struct packed {
    logic wr;
    logic [7:0] wp;
    logic [7:0] d;
    logic [7:0] rp;
    logic [7:0] want;
  } ts_row_t;
  logic clock, rst_n, scl, sda_pull, sda_out, sda_oe, oneshot, sda, a_bit;
  ts_meas_t meas;
  ts_regs_t regs;
  ts_row_t rows [13];
  int mismatches = 0;
  int num_checks = 0;
  int shots = 0;
  logic [15:0] q;
  logic [7:0] r;

  // Open-drain data line with pull-up
  assign sda = !(sda_pull || (sda_oe && !sda_out));
  ts_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  ts_smbus_slave #(.TIMEOUT_CYCLES(TO_CYC), .MAKER_CODE(MAKER)) uut (
    .clock(clock),
    .rst_n(rst_n),
    .scl_clk(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .meas(meas),
    .regs(regs),
    .oneshot(oneshot)
  );
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Trigger pulses counted as they appear
  always @(posedge clock) begin
    if (oneshot === 1'b1) begin
      shots <= shots + 1;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] t;
    logic a;
    m.start();
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, t, a);
    check(a, 1'b0);
    m.xfer(p, 1'b1, t, a);
    check(a, 1'b0);
    m.xfer(d, 1'b1, t, a);
    check(a, 1'b0);
    m.stop();
  endtask
  // Optional pointer write, then repeated start and one or two bytes
  task automatic rd(input logic [7:0] p, input logic setp, input logic two,
                    output logic [15:0] v);
    logic [7:0] t;
    logic a;
    v = 16'h0000;
    if (setp) begin
      m.start();
      m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, t, a);
      m.xfer(p, 1'b1, t, a);
    end
    m.start();
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, t, a);
    check(a, 1'b0);
    m.xfer(8'hFF, !two, t, a);
    v[15:8] = t;
    if (two) begin
      m.xfer(8'hFF, 1'b1, t, a);
      v[7:0] = t;
    end
    m.stop();
  endtask
  // Clock held low while the slave drives a zero bit
  task automatic stall(input logic exp_oe);
    logic [7:0] t;
    logic a;
    m.start();
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, t, a);
    m.xfer(RP_LTL_HI, 1'b1, t, a);
    m.start();
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, t, a);
    // Falling edge keeps every later link edge off the sampling edge
    repeat (TO_CYC + 50) @(negedge clock);
    check(sda_oe, exp_oe);
    m.xfer(8'hFF, 1'b1, t, a);
    m.stop();
  endtask

  initial begin
    rst_n = 1'b0;
    meas = '{local_temp: 12'hABC, remote_temp: 12'h5E7, flags: 8'h00};
    rows = '{
      '{1'b0, 8'h00, 8'h00, RP_CFG, 8'h00},
      '{1'b0, 8'h00, 8'h00, RP_RATE, 8'h08},
      '{1'b0, 8'h00, 8'h00, RP_LTH_HI, 8'h55},
      '{1'b0, 8'h00, 8'h00, P_HYST, 8'h0A},
      '{1'b0, 8'h00, 8'h00, P_FAULT, 8'h81},
      '{1'b0, 8'h00, 8'h00, RP_MAKER, MAKER},
      '{1'b0, 8'h00, 8'h00, 8'h30, 8'h00},
      '{1'b1, WP_CFG, 8'hFF, RP_CFG, 8'hE4},
      '{1'b1, WP_RATE, 8'hFF, RP_RATE, 8'h0F},
      '{1'b1, WP_LTH_HI, 8'h12, RP_LTH_HI, 8'h12},
      '{1'b1, P_LTH_LO, 8'hFF, P_LTH_LO, 8'hF0},
      '{1'b1, P_RES, 8'hFF, P_RES, 8'h1F},
      '{1'b1, P_FAULT, 8'hFF, P_FAULT, 8'h8F}
    };
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // Link edges land on falling edges, never where the design samples
    repeat (3) @(negedge clock);
    // Reset values, masks and split pointers
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].wp, rows[i].d);
      end
      rd(rows[i].rp, 1'b1, 1'b0, q);
      check(q[15:8], rows[i].want);
    end
    // Foreign address left unanswered
    m.start();
    m.xfer({7'h4D, 1'b0}, 1'b1, r, a_bit);
    check(a_bit, 1'b1);
    m.stop();
    // Word reads upper first; pointer survives a plain read
    rd(RP_LT_HI, 1'b1, 1'b1, q);
    check(q, 16'hABC0);
    rd(8'h00, 1'b0, 1'b0, q);
    check(q[15:8], 8'hAB);
    rd(RP_RT_HI, 1'b1, 1'b1, q);
    check(q, 16'h5E70);
    // Read-only place ignores a write
    wr(RP_LT_HI, 8'h5A);
    rd(RP_LT_HI, 1'b1, 1'b0, q);
    check(q[15:8], 8'hAB);
    // Trigger write fires once and stores nothing
    wr(WP_ONESHOT, 8'h77);
    check(16'(shots), 16'h0001);
    // Two-byte write fills the upper then the lower limit byte
    m.start();
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, a_bit);
    m.xfer(WP_RTH_HI, 1'b1, r, a_bit);
    m.xfer(8'h3C, 1'b1, r, a_bit);
    m.xfer(8'hA5, 1'b1, r, a_bit);
    check(a_bit, 1'b0);
    m.stop();
    check(regs.rth_hi, 8'h3C);
    check(regs.rth_lo, 8'hA0);
    // Timeout off keeps the line, on frees it
    wr(P_FAULT, 8'h0E);
    stall(1'b1);
    wr(P_FAULT, 8'h8E);
    stall(1'b0);
    rd(P_FAULT, 1'b1, 1'b0, q);
    check(q[15:8], 8'h8F);
    summarize();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule // ts_smbus_slave_tb
`default_nettype wire
